// ==== inc/dllb_defines.svh ====
/*
  Offsets, field positions, reset values and write masks of the loop
  diagnostic register bank.
  Assumes it is included by bare name from the package and the modules.
*/
`ifndef DLLB_DEFINES_SVH
`define DLLB_DEFINES_SVH

// =====================================================================
// Register indices; the byte address is four times the index.
`define DLLB_IDX_ADC_DETECT 10'h159
`define DLLB_IDX_ADC_DEPTH 10'h15a
`define DLLB_IDX_ADC_REF 10'h15b
`define DLLB_IDX_SPARE 10'h15c
`define DLLB_IDX_AUD_DETECT 10'h15d
`define DLLB_IDX_AUD_DEPTH 10'h15e
`define DLLB_IDX_AUD_REF 10'h15f
`define DLLB_IDX_STATUS 10'h170

// =====================================================================
// Field positions.
`define DLLB_F_SWL_LO 7:6
`define DLLB_F_CHPUMP 5:3
`define DLLB_F_FORCE_DN 2
`define DLLB_F_FORCE_UP 1
`define DLLB_F_FLD_EN 0
`define DLLB_F_DLY_LO 7
`define DLLB_F_DEPTH 6:4
`define DLLB_F_UP_THR 3:1
`define DLLB_F_SWL_HI 0
`define DLLB_F_PAD_REF 7
`define DLLB_F_CURRSET 4:1
`define DLLB_F_DLY_HI 0

// =====================================================================
// Reset values and writable-bit masks.
`define DLLB_RST_DETECT 8'h21
`define DLLB_RST_DEPTH 8'he7
`define DLLB_RST_REF 8'h00
`define DLLB_WM_DETECT 8'hff
`define DLLB_WM_DEPTH 8'hff
`define DLLB_WM_REF 8'h9f

// =====================================================================
// Depth codes with a side effect.
`define DLLB_DEPTH_TEST 3'h7
`define DLLB_DEPTH_FAST 3'h6

`endif

// ==== inc/dllb_pkg.sv ====
/*
  Types shared by the register bank and the per-loop control logic.
  Assumes the defines header is on the include path.
*/
`include "dllb_defines.svh"

package dllb_pkg;

  // ===================================================================
  // Settings of one loop as decoded from its three registers.
  typedef struct packed {
    logic [2:0] swallow_threshold;
    logic false_lock_detect_en;
    logic [2:0] up_override_threshold;
    logic [2:0] depth;
    logic force_up;
    logic force_down;
    logic pad_ref;
    logic [1:0] ref_delay_sel;
    logic [2:0] charge_pump;
    logic [3:0] currset;
  } dllb_loop_cfg_t;

  // Inputs from the analog loop.
  typedef struct packed {
    logic half_tick;
    logic [2:0] pulse_count;
    logic pfd_up;
    logic pfd_down;
  } dllb_loop_in_t;

  // Commands toward the analog loop.
  typedef struct packed {
    logic pfd_up;
    logic pfd_down;
    logic ref_from_pad;
    logic [1:0] ref_delay_sel;
    logic test_pad_route;
    logic fast_lock;
    logic swallow_req;
    logic up_ovr_req;
  } dllb_loop_out_t;

endpackage : dllb_pkg

// ==== verilog/dllb_loop_ctrl.sv ====
/*
  Per-loop control: false-lock decision filter, detector overrides and
  reference selection, all registered.
  Assumes the analog side's inputs are synchronous to pclk.
*/
`timescale 1ns/1ps
`include "dllb_defines.svh"

module dllb_loop_ctrl
  import dllb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire dllb_loop_cfg_t cfg,
  input wire dllb_loop_in_t lin,
  input wire logic clk_out_mode_pad,
  output dllb_loop_out_t lout
);

  // ===================================================================
  // Decision filter.
  logic [1:0] raw;
  logic [1:0] last_reg;
  logic [1:0] dec_next;
  logic [2:0] cnt_reg;
  logic [2:0] cnt_next;
  logic agree;
  logic settle;
  dllb_loop_out_t out_next;

  // Raw decisions compare the pulse count with both thresholds.
  assign raw[1] = cfg.false_lock_detect_en &
                  (lin.pulse_count > cfg.swallow_threshold);
  assign raw[0] = cfg.false_lock_detect_en &
                  (lin.pulse_count < cfg.up_override_threshold);
  assign agree = (raw == last_reg);
  // A larger depth needs more agreeing half periods before a change.
  assign settle = lin.half_tick & agree & (cnt_reg >= cfg.depth);
  assign cnt_next = !lin.half_tick ? cnt_reg :
                    !agree ? 3'h0 :
                    (cnt_reg == 3'h7) ? cnt_reg : cnt_reg + 3'h1;
  // Turning detection off drops any decision at once.
  assign dec_next = !cfg.false_lock_detect_en ? 2'b00 :
                    settle ? raw : {lout.swallow_req, lout.up_ovr_req};

  // Outputs; a software force wins over the comparison result.
  assign out_next.pfd_up = cfg.force_up |
    (~cfg.force_down & (lin.pfd_up | dec_next[0]));
  assign out_next.pfd_down = cfg.force_down |
    (~cfg.force_up & lin.pfd_down);
  assign out_next.ref_from_pad = cfg.pad_ref | clk_out_mode_pad;
  assign out_next.ref_delay_sel = cfg.ref_delay_sel;
  assign out_next.test_pad_route = (cfg.depth == `DLLB_DEPTH_TEST);
  assign out_next.fast_lock = (cfg.depth == `DLLB_DEPTH_FAST);
  assign out_next.swallow_req = dec_next[1];
  assign out_next.up_ovr_req = dec_next[0];

  // Filter state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 2'b00;
      cnt_reg <= 3'h0;
    end else if (pclk_en && lin.half_tick) begin
      last_reg <= raw;
      cnt_reg <= cnt_next;
    end
  end

  // Registered commands.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lout <= '0;
    end else if (pclk_en) begin
      lout <= out_next;
    end
  end

  // ===================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_force_up_wins:
    assert property (cfg.force_up && pclk_en |=> lout.pfd_up)
      else $error("forced up did not reach the detector");
  a_force_dn_wins:
    assert property (cfg.force_down && pclk_en |=> lout.pfd_down)
      else $error("forced down did not reach the detector");
  a_depth_test_pad:
    assert property (pclk_en |=> lout.test_pad_route ==
                     ($past(cfg.depth) == 3'h7))
      else $error("test pad route does not follow depth");
  a_swallow_settle:
    assert property (settle && cfg.false_lock_detect_en && pclk_en
                     |=> lout.swallow_req == $past(raw[1]))
      else $error("swallow decision not taken on settle");
  a_up_ovr_settle:
    assert property (settle && cfg.false_lock_detect_en && pclk_en
                     |=> lout.up_ovr_req == $past(raw[0]))
      else $error("up override decision not taken on settle");
  a_fld_off_clear:
    assert property (!cfg.false_lock_detect_en && pclk_en
                     |=> !lout.swallow_req && !lout.up_ovr_req)
      else $error("decisions remain with detection off");

endmodule : dllb_loop_ctrl

// ==== verilog/dllb_reg_bank.sv ====
/*
  APB register bank for the ADC and audio delay-locked loops, with one
  control instance per loop.
  Assumes an APB master on pclk; pclk_en low freezes every flip-flop.
*/
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "dllb_defines.svh"

module dllb_reg_bank
  import dllb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dllb_loop_in_t adc_in,
  input wire dllb_loop_in_t aud_in,
  input wire logic clk_out_mode_pad,
  output dllb_loop_cfg_t adc_cfg,
  output dllb_loop_cfg_t aud_cfg,
  output dllb_loop_out_t adc_out,
  output dllb_loop_out_t aud_out
);

  // ===================================================================
  // Helpers.

  // Merges written data into a register, keeping unwritable bits zero.
  function automatic logic [7:0] dllb_merge(
    input logic [7:0] old,
    input logic [7:0] wdat,
    input logic [7:0] mask,
    input logic hit
  );
    dllb_merge = hit ? (wdat & mask) : old;
  endfunction : dllb_merge

  // Decodes one loop's three registers into its settings.
  function automatic dllb_loop_cfg_t dllb_decode(
    input logic [7:0] det,
    input logic [7:0] dep,
    input logic [7:0] rf
  );
    dllb_loop_cfg_t c;
    c.swallow_threshold = {dep[`DLLB_F_SWL_HI], det[`DLLB_F_SWL_LO]};
    c.false_lock_detect_en = det[`DLLB_F_FLD_EN];
    c.up_override_threshold = dep[`DLLB_F_UP_THR];
    c.depth = dep[`DLLB_F_DEPTH];
    c.force_up = det[`DLLB_F_FORCE_UP];
    c.force_down = det[`DLLB_F_FORCE_DN];
    c.pad_ref = rf[`DLLB_F_PAD_REF];
    c.ref_delay_sel = {rf[`DLLB_F_DLY_HI], dep[`DLLB_F_DLY_LO]};
    c.charge_pump = det[`DLLB_F_CHPUMP];
    c.currset = rf[`DLLB_F_CURRSET];
    dllb_decode = c;
  endfunction : dllb_decode

  // ===================================================================
  // Storage.
  logic [7:0] adc_det_reg;
  logic [7:0] adc_dep_reg;
  logic [7:0] adc_ref_reg;
  logic [7:0] aud_det_reg;
  logic [7:0] aud_dep_reg;
  logic [7:0] aud_ref_reg;
  logic [31:0] prdata_next;
  logic pslverr_next;
  logic pready_next;

  // ===================================================================
  // Address decode.
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic access;
  logic wr_go;
  logic hit_adc_det;
  logic hit_adc_dep;
  logic hit_adc_ref;
  logic hit_spare;
  logic hit_aud_det;
  logic hit_aud_dep;
  logic hit_aud_ref;
  logic hit_status;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [7:0] status_byte;

  // Word index and phase of the transfer.
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wbyte = pwdata[7:0];

  // One hit per register, only for aligned word addresses.
  assign hit_adc_det = aligned & (idx == `DLLB_IDX_ADC_DETECT);
  assign hit_adc_dep = aligned & (idx == `DLLB_IDX_ADC_DEPTH);
  assign hit_adc_ref = aligned & (idx == `DLLB_IDX_ADC_REF);
  assign hit_spare = aligned & (idx == `DLLB_IDX_SPARE);
  assign hit_aud_det = aligned & (idx == `DLLB_IDX_AUD_DETECT);
  assign hit_aud_dep = aligned & (idx == `DLLB_IDX_AUD_DEPTH);
  assign hit_aud_ref = aligned & (idx == `DLLB_IDX_AUD_REF);
  assign hit_status = aligned & (idx == `DLLB_IDX_STATUS);
  assign mapped = hit_adc_det | hit_adc_dep | hit_adc_ref | hit_spare |
                  hit_aud_det | hit_aud_dep | hit_aud_ref | hit_status;

  // A write lands only at the completing edge, on a mapped word, with
  // the low byte lane strobed.
  assign wr_go = access & pwrite & mapped & pstrb[0] & pclk_en;

  // ===================================================================
  // Read path; data are captured in the setup cycle.

  // Live decision state of both loops.
  assign status_byte = {4'h0, aud_out.up_ovr_req, aud_out.swallow_req,
                        adc_out.up_ovr_req, adc_out.swallow_req};

  // Spare word and reserved bits give zero.
  assign rbyte = hit_adc_det ? adc_det_reg :
                 hit_adc_dep ? adc_dep_reg :
                 hit_adc_ref ? adc_ref_reg :
                 hit_aud_det ? aud_det_reg :
                 hit_aud_dep ? aud_dep_reg :
                 hit_aud_ref ? aud_ref_reg :
                 hit_status ? status_byte : 8'h00;

  // Next bus answer; pready rises for the first access cycle.
  assign prdata_next = setup ? {24'h000000, pwrite ? 8'h00 : rbyte} :
                       prdata;
  assign pslverr_next = setup ? ~mapped : (access ? 1'b0 : pslverr);
  assign pready_next = setup;

  // Bus answer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
    end
  end

  // ===================================================================
  // Register writes; the spare word has no storage at all.

  // ADC loop registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_det_reg <= `DLLB_RST_DETECT;
      adc_dep_reg <= `DLLB_RST_DEPTH;
      adc_ref_reg <= `DLLB_RST_REF;
    end else begin
      adc_det_reg <= dllb_merge(adc_det_reg, wbyte, `DLLB_WM_DETECT,
                                wr_go & hit_adc_det);
      adc_dep_reg <= dllb_merge(adc_dep_reg, wbyte, `DLLB_WM_DEPTH,
                                wr_go & hit_adc_dep);
      adc_ref_reg <= dllb_merge(adc_ref_reg, wbyte, `DLLB_WM_REF,
                                wr_go & hit_adc_ref);
    end
  end

  // Audio loop registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aud_det_reg <= `DLLB_RST_DETECT;
      aud_dep_reg <= `DLLB_RST_DEPTH;
      aud_ref_reg <= `DLLB_RST_REF;
    end else begin
      aud_det_reg <= dllb_merge(aud_det_reg, wbyte, `DLLB_WM_DETECT,
                                wr_go & hit_aud_det);
      aud_dep_reg <= dllb_merge(aud_dep_reg, wbyte, `DLLB_WM_DEPTH,
                                wr_go & hit_aud_dep);
      aud_ref_reg <= dllb_merge(aud_ref_reg, wbyte, `DLLB_WM_REF,
                                wr_go & hit_aud_ref);
    end
  end

  // ===================================================================
  // Decoded settings straight from the register bits.
  assign adc_cfg = dllb_decode(adc_det_reg, adc_dep_reg,
                               adc_ref_reg);
  assign aud_cfg = dllb_decode(aud_det_reg, aud_dep_reg,
                               aud_ref_reg);

  // ===================================================================
  // Loop control instances.
  dllb_loop_ctrl u_adc_loop (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .cfg(adc_cfg),
    .lin(adc_in),
    .clk_out_mode_pad(clk_out_mode_pad),
    .lout(adc_out)
  );

  dllb_loop_ctrl u_aud_loop (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .cfg(aud_cfg),
    .lin(aud_in),
    .clk_out_mode_pad(clk_out_mode_pad),
    .lout(aud_out)
  );

  // ===================================================================
  // Checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Completing write to one given word index.
  sequence s_wr(logic [9:0] w);
    wr_go && idx == w;
  endsequence

  // Setup cycle followed by the completing access of a read.
  sequence s_rd(logic [9:0] w);
    setup && !pwrite && pclk_en && aligned && idx == w
      ##1 (psel && penable && pready);
  endsequence

  a_rst_fld_on:
    assert property ($rose(presetn) |->
                     adc_cfg.false_lock_detect_en &&
                     aud_cfg.false_lock_detect_en)
      else $error("detection not enabled after reset");
  a_rst_depth_dflt:
    assert property ($rose(presetn) |->
                     adc_cfg.depth == 3'h6 && aud_cfg.depth == 3'h6)
      else $error("depth default wrong after reset");
  a_rst_upthr_dflt:
    assert property ($rose(presetn) |->
                     adc_cfg.up_override_threshold == 3'h3)
      else $error("up threshold default wrong after reset");
  a_thr_hi_write:
    assert property (s_wr(10'h15a) |=>
                     adc_cfg.swallow_threshold[2] == $past(pwdata[0]))
      else $error("swallow threshold high bit not written");
  a_adc_pad_ref:
    assert property (adc_cfg.pad_ref && pclk_en |=>
                     adc_out.ref_from_pad)
      else $error("adc loop not on pad reference");
  a_aud_pad_ref:
    assert property (aud_cfg.pad_ref && pclk_en |=>
                     aud_out.ref_from_pad)
      else $error("audio loop not on pad reference");
  a_dly_sel_join:
    assert property (s_wr(10'h15b) ##1 pclk_en |=>
                     adc_out.ref_delay_sel[1] == $past(adc_ref_reg[0]))
      else $error("delay select high bit not passed on");
  a_spare_reads_0:
    assert property (s_rd(10'h15c) |-> prdata == 32'h00000000)
      else $error("spare word did not read zero");
  a_unmapped_err:
    assert property (setup && pclk_en && !mapped |=>
                     pready && pslverr)
      else $error("unmapped access not flagged");
  a_ref_rsvd_zero:
    assert property (adc_ref_reg[6:5] == 2'b00 &&
                     aud_ref_reg[6:5] == 2'b00)
      else $error("reserved reference bits not zero");

  // The audio loop joins its split fields the same way as the ADC loop.
  a_aud_thr_hi:
    assert property (s_wr(10'h15e) |=>
                     aud_cfg.swallow_threshold[2] == $past(pwdata[0]))
      else $error("audio swallow threshold high bit not written");
  a_aud_dly_join:
    assert property (s_wr(10'h15f) ##1 pclk_en |=>
                     aud_out.ref_delay_sel[1] == $past(aud_ref_reg[0]))
      else $error("audio delay select high bit not passed on");

  // The bus answer stands one enabled cycle and carries one byte only.
  a_ready_pulse:
    assert property (pready && pclk_en |=> !pready)
      else $error("ready held past its access cycle");
  a_rd_upper_zero:
    assert property (pready |-> prdata[31:8] == 24'h000000)
      else $error("upper read data not zero");
  a_spare_no_err:
    assert property (s_rd(10'h15c) |-> !pslverr)
      else $error("spare word read flagged an error");

  // A write without the low lane strobe leaves the stored bytes alone.
  a_strb_masked:
    assert property (access && pwrite && !pstrb[0] |=>
                     $stable(adc_det_reg) && $stable(aud_det_reg))
      else $error("unstrobed write changed a register");

  // With the enable low nothing moves, so the loops see no glitch.
  a_en_low_frozen:
    assert property (!pclk_en |=> $stable(pready) && $stable(prdata) &&
                     $stable(adc_dep_reg) && $stable(aud_dep_reg))
      else $error("state moved with the clock enable low");

  // Clock-output mode alone also moves both loops to the pad.
  a_mode_pad_ref:
    assert property (clk_out_mode_pad && pclk_en |=>
                     adc_out.ref_from_pad && aud_out.ref_from_pad)
      else $error("clock-output mode did not select the pad");

endmodule : dllb_reg_bank

// ==== bench/tb_dll_diagnostic_register_bank.sv ====
/*
  Self-checking bench for the loop diagnostic register bank.
  Assumes the package and the defines header are compiled first.
*/
`timescale 1ns/1ps

module tb_dll_diagnostic_register_bank
  import dllb_pkg::*;
;
  // ===================================================================
  // Stimulus and observation signals.
  typedef struct packed {
    logic [9:0] idx;
    logic [3:0] st;
    logic [7:0] wd;
    logic [7:0] rx;
    logic ex;
  } dllb_tb_row_t;
  logic pclk = 1'b0;
  logic presetn, pclk_en, psel, penable, pwrite, clk_out_mode_pad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic pready, pslverr, er;
  dllb_loop_in_t adc_in, aud_in;
  dllb_loop_cfg_t adc_cfg, aud_cfg, ccfg;
  dllb_loop_out_t adc_out, aud_out, cur;
  logic [9:0] b;
  int err_count = 0;
  int n_compared = 0;
  localparam logic [7:0] dflt [7] = '{8'h21, 8'he7, 8'h00, 8'h00,
                                      8'h21, 8'he7, 8'h00};
  localparam dllb_tb_row_t rows [9] = '{
    '{10'h159, 4'h1, 8'hff, 8'hff, 1'b0},
    '{10'h15a, 4'h1, 8'h00, 8'h00, 1'b0},
    '{10'h15b, 4'h1, 8'hff, 8'h9f, 1'b0},
    '{10'h15c, 4'h1, 8'hff, 8'h00, 1'b0},
    '{10'h15d, 4'h1, 8'h5a, 8'h5a, 1'b0},
    '{10'h15e, 4'h1, 8'h81, 8'h81, 1'b0},
    '{10'h15f, 4'h1, 8'he1, 8'h81, 1'b0},
    '{10'h15d, 4'h0, 8'hff, 8'h5a, 1'b0},
    '{10'h160, 4'h1, 8'hff, 8'h00, 1'b1}};

  // The design under test, every port by name.
  dllb_reg_bank dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .adc_in(adc_in), .aud_in(aud_in), .clk_out_mode_pad(clk_out_mode_pad),
    .adc_cfg(adc_cfg), .aud_cfg(aud_cfg), .adc_out(adc_out),
    .aud_out(aud_out)
  );

  // A 100 MHz clock.
  always #5 pclk = ~pclk;

  // ===================================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // One APB transfer; it waits for pready and takes data at that edge.
  task automatic apb(input logic w, input logic [9:0] idx,
                     input logic [7:0] wd, input logic [3:0] st);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(pready), 32'h1, "no answer");
  endtask : apb

  task automatic wr(input logic [9:0] idx, input logic [7:0] wd);
    apb(1'b1, idx, wd, 4'h1);
  endtask : wr

  // Lets a write reach the configuration and then the loop outputs.
  task automatic settle;
    repeat (3) @(posedge pclk);
    #1;
  endtask : settle

  // Feeds a pulse count to the ADC loop over k half periods.
  task automatic ticks(input logic [2:0] c, input int k);
    @(posedge pclk);
    adc_in.pulse_count <= c;
    repeat (k) begin
      @(posedge pclk);
      adc_in.half_tick <= 1'b1;
      @(posedge pclk);
      adc_in.half_tick <= 1'b0;
    end
    settle;
  endtask : ticks

  // Holds reset for 12 cycles and checks every default afterwards.
  task automatic do_reset;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (11) @(posedge pclk);
    #1;
    chk(32'(adc_out), 32'h0, "outputs in reset");
    @(posedge pclk);
    presetn <= 1'b1;
    settle;
    chk(32'(adc_cfg.swallow_threshold), 32'h4, "swallow dflt");
    chk(32'(aud_cfg.false_lock_detect_en), 32'h1, "detect dflt");
    chk(32'(adc_cfg.up_override_threshold), 32'h3, "up dflt");
    chk(32'(aud_cfg.depth), 32'h6, "depth dflt");
    chk(32'(aud_out.fast_lock), 32'h1, "fast dflt");
    chk(32'(adc_out.ref_delay_sel), 32'h1, "delay dflt");
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 10'h159 + 10'(i), 8'h00, 4'h0);
      chk(rd, 32'(dflt[i]), "reset value");
    end
    $display("reset test done");
  endtask : do_reset

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude;
    $display("compared %0d, mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // ===================================================================
  // Cuts a hung run short.
  initial begin
    #100000;
    err_count++;
    conclude;
  end

  // Main sequence.
  initial begin
    {presetn, pclk_en, psel, penable, pwrite, clk_out_mode_pad} = 6'h10;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    adc_in = '0;
    aud_in = '0;
    do_reset;
    // Access kinds, reserved bits, strobe and unmapped index.
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd, rows[i].st);
      apb(1'b0, rows[i].idx, 8'h00, 4'h0);
      chk(rd, 32'(rows[i].rx), "read back");
      chk(32'(er), 32'(rows[i].ex), "error flag");
    end
    $display("table test done");
    // Field assembly, forces, depth codes and reference per loop.
    for (int l = 0; l < 2; l++) begin
      b = (l == 1) ? 10'h15d : 10'h159;
      wr(b, 8'h42);
      wr(b + 10'h1, 8'h71);
      wr(b + 10'h2, 8'h81);
      settle;
      cur = (l == 1) ? aud_out : adc_out;
      ccfg = (l == 1) ? aud_cfg : adc_cfg;
      chk(32'(ccfg.swallow_threshold), 32'h5, "swallow 5");
      chk(32'({cur.pfd_up, cur.pfd_down}), 32'h2, "up only");
      chk(32'({cur.test_pad_route, cur.fast_lock}), 32'h2, "d7");
      chk(32'(cur.ref_from_pad), 32'h1, "pad ref");
      chk(32'(cur.ref_delay_sel), 32'h2, "delay 2");
      wr(b, 8'h84);
      wr(b + 10'h1, 8'he0);
      wr(b + 10'h2, 8'h00);
      settle;
      cur = (l == 1) ? aud_out : adc_out;
      ccfg = (l == 1) ? aud_cfg : adc_cfg;
      chk(32'(ccfg.swallow_threshold), 32'h2, "swallow 2");
      chk(32'({cur.pfd_up, cur.pfd_down}), 32'h1, "down only");
      chk(32'({cur.test_pad_route, cur.fast_lock}), 32'h1, "d6");
      chk(32'(cur.ref_from_pad), 32'h0, "crystal");
      chk(32'(cur.ref_delay_sel), 32'h1, "delay 1");
      wr(b, 8'h06);
      wr(b + 10'h1, 8'h50);
      settle;
      cur = (l == 1) ? aud_out : adc_out;
      chk(32'({cur.pfd_up, cur.pfd_down}), 32'h3, "both");
      chk(32'({cur.test_pad_route, cur.fast_lock}), 32'h0, "d5");
    end
    // With the enable low the outputs hold; then the mode takes effect.
    @(posedge pclk);
    pclk_en <= 1'b0;
    clk_out_mode_pad <= 1'b1;
    settle;
    chk(32'(aud_out.ref_from_pad), 32'h0, "frozen by enable");
    @(posedge pclk);
    pclk_en <= 1'b1;
    settle;
    chk(32'(aud_out.ref_from_pad), 32'h1, "mode pad");
    @(posedge pclk);
    clk_out_mode_pad <= 1'b0;
    $display("field test done");
    // False-lock decisions on the ADC loop: threshold 2, up below 3.
    wr(10'h15a, 8'h06);
    wr(10'h159, 8'h81);
    ticks(3'h5, 4);
    chk(32'({adc_out.swallow_req, adc_out.up_ovr_req}), 32'h2, "5");
    ticks(3'h3, 4);
    chk(32'({adc_out.swallow_req, adc_out.up_ovr_req}), 32'h2, "3");
    ticks(3'h1, 4);
    chk(32'({adc_out.swallow_req, adc_out.up_ovr_req}), 32'h1, "1");
    chk(32'(adc_out.pfd_up), 32'h1, "up from decision");
    apb(1'b0, 10'h170, 8'h00, 4'h0);
    chk(rd, 32'h00000002, "status word");
    wr(10'h15a, 8'h56);
    ticks(3'h5, 2);
    chk(32'(adc_out.up_ovr_req), 32'h1, "held by depth");
    ticks(3'h5, 8);
    chk(32'(adc_out.swallow_req), 32'h1, "after depth");
    wr(10'h159, 8'h80);
    settle;
    chk(32'(adc_out.swallow_req), 32'h0, "detect off");
    $display("decision test done");
    do_reset;
    conclude;
  end
endmodule : tb_dll_diagnostic_register_bank
